// File: rtl/cid_pkg.sv
// shared constants, encodings and carriers of the chip identity bank
package cid_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int           CID_ADDR_W       = 8;
  localparam int           CID_DATA_W       = 32;
  localparam int           CID_KB_W         = 12;
  localparam logic [7:0]   CID_OFS_WORD     = 8'h00;
  localparam logic [7:0]   CID_OFS_EXT      = 8'h04;
  localparam logic [31:0]  CID_ZERO_WORD    = 32'h0000_0000;
  localparam logic [31:0]  CID_RESET_DATA   = 32'h0000_0000;
  localparam logic [11:0]  CID_KB_NONE      = 12'h000;

  // ----------------------------------------------------------------
  // program memory type codes
  // ----------------------------------------------------------------
  localparam logic [2:0]   CID_TYP_ROM       = 3'h0;
  localparam logic [2:0]   CID_TYP_ROMLESS   = 3'h1;
  localparam logic [2:0]   CID_TYP_FLASH     = 3'h2;
  localparam logic [2:0]   CID_TYP_ROM_FLASH = 3'h3;
  localparam logic [2:0]   CID_TYP_SRAM      = 3'h4;

  // ----------------------------------------------------------------
  // size tables, indexed by field code, in kilobytes
  // ----------------------------------------------------------------
  localparam logic [3:0]   CID_SZ_160K_CODE = 4'h8;
  localparam logic [11:0]  CID_NVP_KB [0:15] = '{
    12'h000, 12'h008, 12'h010, 12'h020, 12'h000, 12'h040, 12'h000, 12'h080,
    12'h0A0, 12'h100, 12'h200, 12'h000, 12'h400, 12'h000, 12'h800, 12'h000};
  // one bit per code, set where the code is reserved
  localparam logic [15:0]  CID_NVP_RSV = 16'hA850;
  localparam logic [11:0]  CID_RAM_KB [0:15] = '{
    12'h030, 12'h0C0, 12'h180, 12'h006, 12'h018, 12'h004, 12'h050, 12'h0A0,
    12'h008, 12'h010, 12'h020, 12'h040, 12'h080, 12'h100, 12'h060, 12'h200};
  localparam logic [15:0]  CID_RAM_RSV = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       extension_present_flag;
    logic [2:0] program_memory_type;
    logic [7:0] architecture_code;
    logic [3:0] internal_ram_size;
    logic [3:0] second_program_memory_size;
    logic [3:0] program_memory_size;
    logic [2:0] processor_core_code;
    logic [4:0] version;
  } cid_word_t;

  typedef struct packed {
    logic                  rd_stb;
    logic                  wr_stb;
    logic [CID_ADDR_W-1:0] addr;
    logic [CID_DATA_W-1:0] wdata;
  } cid_bus_req_t;

endpackage

// File: rtl/cid_code_decode.sv
// table decode of a four-bit memory size code into kilobytes
`timescale 1ns/1ps
module cid_code_decode
  import cid_pkg::*;
#(
  parameter logic [11:0] KB_TABLE [0:15] = CID_NVP_KB,
  parameter logic [15:0] RSV_MASK        = CID_NVP_RSV,
  parameter bit          ALLOW_160K      = 1'b1
)
(
  input  wire logic [3:0]          code,
  output logic      [CID_KB_W-1:0] kbytes,
  output logic                     reserved
);

  logic rsv;

  // the second program size treats the 160K code as reserved
  always_comb
  begin
    rsv = RSV_MASK[code] | (!ALLOW_160K && (code == CID_SZ_160K_CODE));
    reserved = rsv;
    kbytes   = rsv ? CID_KB_NONE : KB_TABLE[code];
  end

endmodule

// File: rtl/cid_type_split.sv
// splits the program memory sizes into rom and flash capacity by type
`timescale 1ns/1ps
module cid_type_split
  import cid_pkg::*;
(
  input  wire logic [2:0]          mem_type,
  input  wire logic [CID_KB_W-1:0] first_kb,
  input  wire logic [CID_KB_W-1:0] second_kb,
  output logic      [CID_KB_W-1:0] rom_kb,
  output logic      [CID_KB_W-1:0] flash_kb,
  output logic                     type_reserved
);

  always_comb
  begin
    rom_kb        = CID_KB_NONE;
    flash_kb      = CID_KB_NONE;
    type_reserved = 1'b0;
    case (mem_type)
      CID_TYP_ROM:       rom_kb   = first_kb;
      CID_TYP_ROMLESS:   flash_kb = first_kb;
      CID_TYP_FLASH:     flash_kb = first_kb;
      CID_TYP_ROM_FLASH:
      begin
        rom_kb   = first_kb;
        flash_kb = second_kb;
      end
      // emulated rom sits in ram, so no nonvolatile capacity is reported
      CID_TYP_SRAM:      rom_kb   = CID_KB_NONE;
      default:           type_reserved = 1'b1;
    endcase
  end

endmodule

// File: rtl/cid_bank.sv
// read-only chip identity register bank with its plain register port
`timescale 1ns/1ps

// How it works
// - main word at offset 0, extension at offset 4, both read only.
// - version field reports the fitted silicon revision.
// - program size codes map to fixed kilobyte sizes; five codes reserved.
// - second size uses the same table except code 8 is reserved.
// - ram size field maps all sixteen codes to fixed kilobyte sizes.
// - memory type code selects rom, romless, flash, rom plus flash, sram.
// - with type 3, first size is rom and second size is flash.
// - extension flag is one only when a meaningful extension word exists.
// - extension word reads all zeros whenever the flag is zero.
// - both words are hard-wired constants that software cannot alter.
module cid_bank
#(
  // every identity value below is arbitrary and set per product
  parameter logic [4:0]  VERSION_CODE    = 5'h01,
  parameter logic [2:0]  CORE_CODE       = 3'h1,
  parameter logic [3:0]  PROG_SIZE_CODE  = 4'h9,
  parameter logic [3:0]  PROG2_SIZE_CODE = 4'h0,
  parameter logic [3:0]  RAM_SIZE_CODE   = 4'hB,
  parameter logic [7:0]  ARCHITECTURE_CODE_CODE       = 8'h5A,
  parameter logic [2:0]  MEM_TYPE_CODE   = 3'h2,
  parameter logic        EXT_FLAG        = 1'b0,
  parameter logic [31:0] EXT_VALUE       = 32'h0000_0000
)
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire cid_pkg::cid_bus_req_t     bus_req,
  output logic    [cid_pkg::CID_DATA_W-1:0] rd_data,
  output logic    [cid_pkg::CID_KB_W-1:0]   rom_kb,
  output logic    [cid_pkg::CID_KB_W-1:0]   flash_kb,
  output logic    [cid_pkg::CID_KB_W-1:0]   ram_kb,
  output logic                              cfg_fault
);

  import cid_pkg::*;

  // ----------------------------------------------------------------
  // hard-wired identity words
  // ----------------------------------------------------------------
  cid_word_t             id_fields;
  logic [CID_DATA_W-1:0] id_word;
  logic [CID_DATA_W-1:0] ext_word;

  always_comb
  begin
    id_fields.version                    = VERSION_CODE;
    id_fields.processor_core_code        = CORE_CODE;
    id_fields.program_memory_size        = PROG_SIZE_CODE;
    id_fields.second_program_memory_size = PROG2_SIZE_CODE;
    id_fields.internal_ram_size          = RAM_SIZE_CODE;
    id_fields.architecture_code          = ARCHITECTURE_CODE_CODE;
    id_fields.program_memory_type        = MEM_TYPE_CODE;
    id_fields.extension_present_flag     = EXT_FLAG;
    id_word  = id_fields;
    // a stray extension value must never leak when the flag says none
    ext_word = EXT_FLAG ? EXT_VALUE : CID_ZERO_WORD;
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [CID_KB_W-1:0] prog_kb;
  logic [CID_KB_W-1:0] prog2_kb;
  logic [CID_KB_W-1:0] ram_kb_dec;
  logic [CID_KB_W-1:0] rom_kb_dec;
  logic [CID_KB_W-1:0] flash_kb_dec;
  logic                prog_rsv;
  logic                prog2_rsv;
  logic                ram_rsv;
  logic                type_rsv;

  cid_code_decode #(
    .KB_TABLE   (CID_NVP_KB),
    .RSV_MASK   (CID_NVP_RSV),
    .ALLOW_160K (1'b1)
  ) u_prog_size (
    .code     (id_fields.program_memory_size),
    .kbytes   (prog_kb),
    .reserved (prog_rsv)
  );

  cid_code_decode #(
    .KB_TABLE   (CID_NVP_KB),
    .RSV_MASK   (CID_NVP_RSV),
    .ALLOW_160K (1'b0)
  ) u_prog2_size (
    .code     (id_fields.second_program_memory_size),
    .kbytes   (prog2_kb),
    .reserved (prog2_rsv)
  );

  cid_code_decode #(
    .KB_TABLE   (CID_RAM_KB),
    .RSV_MASK   (CID_RAM_RSV),
    .ALLOW_160K (1'b1)
  ) u_ram_size (
    .code     (id_fields.internal_ram_size),
    .kbytes   (ram_kb_dec),
    .reserved (ram_rsv)
  );

  cid_type_split u_type (
    .mem_type      (id_fields.program_memory_type),
    .first_kb      (prog_kb),
    .second_kb     (prog2_kb),
    .rom_kb        (rom_kb_dec),
    .flash_kb      (flash_kb_dec),
    .type_reserved (type_rsv)
  );

  // ----------------------------------------------------------------
  // decoded capacity outputs
  // ----------------------------------------------------------------
  logic [CID_KB_W-1:0] rom_kb_r;
  logic [CID_KB_W-1:0] flash_kb_r;
  logic [CID_KB_W-1:0] ram_kb_r;
  logic                cfg_fault_r;
  logic                fault_nxt;

  // the second size only matters when the type pairs rom with flash
  assign fault_nxt = prog_rsv | ram_rsv | type_rsv |
                     (prog2_rsv && (MEM_TYPE_CODE == CID_TYP_ROM_FLASH));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rom_kb_r    <= CID_KB_NONE;
      flash_kb_r  <= CID_KB_NONE;
      ram_kb_r    <= CID_KB_NONE;
      cfg_fault_r <= 1'b0;
    end
    else
    begin
      rom_kb_r    <= rom_kb_dec;
      flash_kb_r  <= flash_kb_dec;
      ram_kb_r    <= ram_kb_dec;
      cfg_fault_r <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [CID_DATA_W-1:0] rd_data_r;
  logic [CID_DATA_W-1:0] rd_data_nxt;
  logic                  hit_word;
  logic                  hit_ext;

  assign hit_word = (bus_req.addr == CID_OFS_WORD);
  assign hit_ext  = (bus_req.addr == CID_OFS_EXT);

  // writes never reach any storage; unmapped reads and idle cycles give zero
  always_comb
  begin
    rd_data_nxt = CID_ZERO_WORD;
    if (bus_req.rd_stb && hit_word)
      rd_data_nxt = id_word;
    else if (bus_req.rd_stb && hit_ext)
      rd_data_nxt = ext_word;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data_r <= CID_RESET_DATA;
    else
      rd_data_r <= rd_data_nxt;
  end

  assign rd_data   = rd_data_r;
  assign rom_kb    = rom_kb_r;
  assign flash_kb  = flash_kb_r;
  assign ram_kb    = ram_kb_r;
  assign cfg_fault = cfg_fault_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_main_read: assert property (
    bus_req.rd_stb && bus_req.addr == CID_OFS_WORD |=> rd_data == id_word)
    else $error("main word read returned wrong data");

  a_ext_read: assert property (
    bus_req.rd_stb && bus_req.addr == CID_OFS_EXT |=> rd_data == ext_word)
    else $error("extension read returned wrong data");

  a_idle_zero: assert property (
    !bus_req.rd_stb |=> rd_data == CID_ZERO_WORD)
    else $error("read data present without a read");

  a_version_field: assert property (
    bus_req.rd_stb && hit_word |=> rd_data[4:0] == VERSION_CODE)
    else $error("version field wrong");

  a_flag_bit: assert property (
    bus_req.rd_stb && hit_word |=> rd_data[CID_DATA_W-1] == EXT_FLAG)
    else $error("extension flag wrong");

  a_ext_cleared: assert property (
    bus_req.rd_stb && hit_ext && !EXT_FLAG |=> rd_data == CID_ZERO_WORD)
    else $error("extension word not zero while flag clear");

  a_write_ignored: assert property (
    bus_req.wr_stb ##1 (bus_req.rd_stb && hit_word) |=> rd_data == id_fields)
    else $error("write altered the main word");

  a_word_stable: assert property (
    (bus_req.rd_stb && hit_word) ##1 (bus_req.rd_stb && hit_word)
      |=> rd_data == $past(rd_data))
    else $error("main word changed between reads");

  a_rom_flash_split: assert property (
    $past(!rst) && MEM_TYPE_CODE == CID_TYP_ROM_FLASH
      |-> rom_kb == prog_kb && flash_kb == prog2_kb)
    else $error("rom and flash sizes not split");

  a_second_160k: assert property (
    id_fields.second_program_memory_size == CID_SZ_160K_CODE |-> prog2_rsv)
    else $error("160K code accepted in second size");

  a_ram_valid: assert property (
    $past(!rst) |-> ram_kb != CID_KB_NONE)
    else $error("ram size decoded as none");

  c_main_read: cover property (bus_req.rd_stb && hit_word ##1 rd_data != CID_ZERO_WORD);
  c_ext_read:  cover property (bus_req.rd_stb && hit_ext);
  c_wr_rd:     cover property (bus_req.wr_stb ##1 bus_req.rd_stb);
  c_unmapped:  cover property (bus_req.rd_stb && !hit_word && !hit_ext);

endmodule

// File: verif/test_chip_identity_registers.sv
// self-checking bench for the chip identity register bank
`timescale 1ns/1ps
module test_chip_identity_registers;
  import cid_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed outputs
  // ----------------------------------------------------------------
  logic         clk;
  logic         rst;
  cid_bus_req_t bus_req;
  int           mismatches;
  int           n_compared;
  logic [31:0]  rd_s    [16];
  logic [11:0]  rom_s   [16];
  logic [11:0]  flash_s [16];
  logic [11:0]  ram_s   [16];
  logic         fault_s [16];
  logic [31:0]  rd_t    [8];
  logic [11:0]  rom_t   [8];
  logic [11:0]  flash_t [8];
  logic [11:0]  ram_t   [8];
  logic         fault_t [8];

  // sizes in kilobytes by code, kept apart from the design's own tables
  logic [11:0] nvp_kb [16] = '{12'h000, 12'h008, 12'h010, 12'h020, 12'h000, 12'h040,
    12'h000, 12'h080, 12'h0A0, 12'h100, 12'h200, 12'h000, 12'h400, 12'h000, 12'h800,
    12'h000};
  logic [11:0] ram_kb_tab [16] = '{12'h030, 12'h0C0, 12'h180, 12'h006, 12'h018, 12'h004,
    12'h050, 12'h0A0, 12'h008, 12'h010, 12'h020, 12'h040, 12'h080, 12'h100, 12'h060,
    12'h200};
  // reserved first size codes, plus code 8 of the second size
  localparam logic [15:0] FAULT_S = 16'hA950;

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // one bank per size code (rom plus flash), one per memory type
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++)
  begin : g_size
    cid_bank #(
      .VERSION_CODE    (5'(i)),
      .CORE_CODE       (3'(i)),
      .PROG_SIZE_CODE  (4'(i)),
      .PROG2_SIZE_CODE (4'(i)),
      .RAM_SIZE_CODE   (4'(i)),
      .ARCHITECTURE_CODE_CODE       (8'(8'h10 + i)),
      .MEM_TYPE_CODE   (3'h3),
      .EXT_FLAG        (1'(i)),
      .EXT_VALUE       (32'(32'h5A5A_0000 + i))
    ) dut (
      .clk       (clk),
      .rst       (rst),
      .bus_req   (bus_req),
      .rd_data   (rd_s[i]),
      .rom_kb    (rom_s[i]),
      .flash_kb  (flash_s[i]),
      .ram_kb    (ram_s[i]),
      .cfg_fault (fault_s[i])
    );
  end

  for (genvar t = 0; t < 8; t++)
  begin : g_type
    cid_bank #(
      .PROG2_SIZE_CODE (4'h5),
      .MEM_TYPE_CODE   (3'(t))
    ) dut (
      .clk       (clk),
      .rst       (rst),
      .bus_req   (bus_req),
      .rd_data   (rd_t[t]),
      .rom_kb    (rom_t[t]),
      .flash_kb  (flash_t[t]),
      .ram_kb    (ram_t[t]),
      .cfg_fault (fault_t[t])
    );
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] word_s(int i);
    return {i[0], 3'h3, 8'(8'h10 + i), 4'(i), 4'(i), 4'(i), 3'(i), 5'(i)};
  endfunction

  function automatic logic [31:0] word_t(int t);
    return {1'b0, 3'(t), 8'h5A, 4'hB, 4'h5, 4'h9, 3'h1, 5'h01};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw 0x%08h, expected 0x%08h", $time, seen, exp);
    end
  endtask

  // one bus cycle, then every bank's read data in the cycle after it
  task automatic xfer(input logic rd, input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    bus_req <= '{rd_stb: rd, wr_stb: wr, addr: a, wdata: d};
    @(posedge clk);
    #1;
    for (int i = 0; i < 16; i++)
    begin
      if (rd && a == 8'h00) check(rd_s[i], word_s(i));
      else if (rd && a == 8'h04) check(rd_s[i], i[0] ? 32'h5A5A_0000 + i : 32'h0);
      else check(rd_s[i], 32'h0);
    end
    for (int t = 0; t < 8; t++)
    begin
      if (rd && a == 8'h00) check(rd_t[t], word_t(t));
      else check(rd_t[t], 32'h0);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    check(rom_s[9], 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 16; i++)
    begin
      check(rom_s[i], nvp_kb[i]);
      check(flash_s[i], i == 8 ? 12'h000 : nvp_kb[i]);
      check(ram_s[i], ram_kb_tab[i]);
      check(fault_s[i], FAULT_S[i]);
    end
    for (int t = 0; t < 8; t++)
    begin
      check(rom_t[t], (t == 0 || t == 3) ? 12'h100 : 12'h000);
      check(flash_t[t], (t == 1 || t == 2) ? 12'h100 : (t == 3 ? 12'h040 : 12'h000));
      check(fault_t[t], t > 4);
      check(ram_t[t], 12'h040);
    end
    $display("test decode done");
    // back-to-back reads, then the unmapped and unaligned places
    xfer(1'b1, 1'b0, 8'h00, 32'h0);
    xfer(1'b1, 1'b0, 8'h04, 32'h0);
    xfer(1'b1, 1'b0, 8'h00, 32'h0);
    xfer(1'b1, 1'b0, 8'h08, 32'h0);
    xfer(1'b1, 1'b0, 8'h01, 32'h0);
    xfer(1'b0, 1'b0, 8'h00, 32'h0);
    $display("test reads done");
    // writes must leave both words as they were
    xfer(1'b0, 1'b1, 8'h00, 32'hFFFF_FFFF);
    xfer(1'b0, 1'b1, 8'h04, 32'hFFFF_FFFF);
    xfer(1'b1, 1'b0, 8'h00, 32'h0);
    xfer(1'b0, 1'b1, 8'h04, 32'hA5A5_A5A5);
    xfer(1'b1, 1'b0, 8'h04, 32'h0);
    $display("test writes done");
    // a second reset in mid-run keeps the hard-wired values
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    xfer(1'b1, 1'b0, 8'h00, 32'h0);
    xfer(1'b1, 1'b0, 8'h04, 32'h0);
    xfer(1'b0, 1'b0, 8'h00, 32'h0);
    $display("test second reset done");
    finish_test;
  end

  // cuts a hung run short
  initial
  begin
    repeat (2000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: run did not end in time", $time);
    finish_test;
  end
endmodule
